/* File: rca_pkg.sv */
/*
 * Shared constants and types for the 8-bit core execution pipeline.
 * Assumes one clock domain; the program memory answers one cycle after its address.
 */
package rca_pkg;

    // Data memory locations of the special function registers
    localparam logic [7:0] SFR_IND   = 8'h00;
    localparam logic [7:0] SFR_PTR   = 8'h01;
    localparam logic [7:0] SFR_PCL   = 8'h02;
    localparam logic [7:0] SFR_PCH   = 8'h03;
    localparam logic [7:0] SFR_FLAGS = 8'h04;
    localparam logic [7:0] SFR_ACC   = 8'h05;
    localparam logic [7:0] SFR_PRODL = 8'h06;
    localparam logic [7:0] SFR_PRODH = 8'h07;
    localparam logic [7:0] SFR_TBLL  = 8'h08;
    localparam logic [7:0] SFR_TBLH  = 8'h09;

    // Bit positions in the alu flags register
    localparam int FLG_C  = 0;
    localparam int FLG_HC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_SW = 3;

    // Instruction classes, bits 15:12
    localparam logic [3:0] OP_ALU_F = 4'h0;
    localparam logic [3:0] OP_ALU_L = 4'h1;
    localparam logic [3:0] OP_SHF   = 4'h2;
    localparam logic [3:0] OP_MOVFF = 4'h3;
    localparam logic [3:0] OP_MUL   = 4'h4;
    localparam logic [3:0] OP_GOTO  = 4'h5;
    localparam logic [3:0] OP_SKIP  = 4'h6;
    localparam logic [3:0] OP_TBLRD = 4'h7;
    localparam logic [3:0] OP_TBLWR = 4'h8;

    // Function codes, bits 11:9
    localparam logic [2:0] FN_ADD  = 3'h0;
    localparam logic [2:0] FN_ADDC = 3'h1;
    localparam logic [2:0] FN_SUB  = 3'h2;
    localparam logic [2:0] FN_SUBB = 3'h3;
    localparam logic [2:0] FN_AND  = 3'h4;
    localparam logic [2:0] FN_OR   = 3'h5;
    localparam logic [2:0] FN_XOR  = 3'h6;
    localparam logic [2:0] FN_MOV  = 3'h7;
    localparam logic [2:0] SH_RLC  = 3'h0;
    localparam logic [2:0] SH_RRC  = 3'h1;
    localparam logic [2:0] SH_RL   = 3'h2;
    localparam logic [2:0] SH_RR   = 3'h3;
    localparam logic [2:0] SH_INC  = 3'h4;
    localparam logic [2:0] SH_DEC  = 3'h5;
    localparam logic [2:0] SH_CLR  = 3'h6;
    localparam logic [2:0] SH_COM  = 3'h7;

    // Program source modes
    localparam logic [1:0] MODE_INT = 2'h0;
    localparam logic [1:0] MODE_EXT = 2'h1;
    localparam logic [1:0] MODE_MIX = 2'h2;
    localparam logic [15:0] PM_INT_TOP = 16'h0FFF;

    // Register bus map
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_PC       = 8'h08;
    localparam logic [7:0] REG_ACC      = 8'h0C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_PROT = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam int IRQ_WRAP  = 0;
    localparam int IRQ_TBLWR = 1;
    localparam int IRQ_BADOP = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {TBL_IDLE, TBL_WAIT, TBL_DATA} rca_tbl_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic        ext_sel;
        logic        protect;
    } rca_pm_req_type;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       hc;
        logic       sw;
        logic       upd_c;
        logic       upd_arith;
    } rca_alu_type;

endpackage

/* File: rca_core.sv */
/*
 * Execution core: two-stage fetch/execute pipeline, 8-bit ALU, 8x8 multiplier,
 * internal data memory with mapped special registers, AXI4-Lite control slave.
 * Assumes a program memory on aclk returning the addressed word one cycle later.
 */
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps

module rca_core (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output rca_pkg::rca_pm_req_type      pm_req,
    input  wire logic [15:0]             pm_rdata,
    output logic                         irq
);

    typedef struct packed {
        logic [255:0][7:0]          dmem;
        rca_pkg::rca_pm_req_type    pm;
        logic                       ex_valid;
        logic [15:0]                ex_pc;
        rca_pkg::rca_tbl_state_type tbl;
        logic                       tbl_read;
        logic                       tbl_hi;
        logic [7:0]                 tbl_dst;
        logic [15:0]                resume;
        logic [7:0]                 ctrl;
        logic [7:0]                 irq_stat;
        logic [7:0]                 irq_mask;
        logic                       irq;
        logic                       aw_got;
        logic [7:0]                 aw_addr;
        logic                       w_got;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } rca_state_type;

    rca_state_type            s_r;
    rca_state_type            s_nxt;
    rca_pkg::rca_alu_type     alu;
    logic [15:0]              ir;
    logic [3:0]               op;
    logic [2:0]               fn;
    logic [7:0]               fa;
    logic [7:0]               opnd;
    logic [7:0]               acc;
    logic [7:0]               flags;
    logic [7:0]               b_in;
    logic                     alu_en;
    logic                     wr_en;
    logic [7:0]               wr_addr;
    logic [7:0]               wr_val;
    logic                     redirect;
    logic [15:0]              target;
    logic                     squash;
    logic [7:0]               events;
    logic                     rd_clear;
    logic [15:0]              prod;
    logic [7:0]               mv_src;

    // Indirect slot maps through the pointer register
    function automatic logic [7:0] resolve(input logic [7:0] f, input logic [7:0] ptr);
        return (f == rca_pkg::SFR_IND) ? ptr : f;
    endfunction

    function automatic logic [7:0] rd_file(input logic [7:0] a);
        if (a == rca_pkg::SFR_PCL) begin
            return s_r.ex_pc[7:0];
        end
        if (a == rca_pkg::SFR_IND) begin
            return 8'h00;
        end
        return s_r.dmem[a];
    endfunction

    function automatic rca_pkg::rca_alu_type alu_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
        rca_pkg::rca_alu_type r;
        logic [8:0]           s;
        logic [4:0]           h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res = s[7:0];
        r.c = s[8];
        r.hc = h[4];
        r.sw = s[8] ^ (s[7] ^ a[7] ^ b[7]);
        r.upd_c = 1'b1;
        r.upd_arith = 1'b1;
        return r;
    endfunction

    function automatic rca_pkg::rca_alu_type alu_logic(input logic [7:0] v);
        rca_pkg::rca_alu_type r;
        r = '0;
        r.res = v;
        return r;
    endfunction

    always_comb begin
        s_nxt = s_r;
        alu = '0;
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_val = 8'h00;
        redirect = 1'b0;
        target = 16'h0000;
        squash = 1'b0;
        events = 8'h00;
        rd_clear = 1'b0;
        alu_en = 1'b0;
        ir = pm_rdata;
        op = ir[15:12];
        fn = ir[11:9];
        fa = resolve(ir[7:0], s_r.dmem[rca_pkg::SFR_PTR]);
        opnd = rd_file(fa);
        acc = s_r.dmem[rca_pkg::SFR_ACC];
        flags = s_r.dmem[rca_pkg::SFR_FLAGS];
        b_in = (op == rca_pkg::OP_ALU_L) ? ir[7:0] : opnd;
        prod = acc * opnd;
        mv_src = resolve({4'h0, ir[11:8]}, s_r.dmem[rca_pkg::SFR_PTR]);

        // Default: next sequential fetch overlaps this execute
        s_nxt.pm.addr = s_r.pm.addr + 16'h0001;
        s_nxt.pm.we = 1'b0;
        s_nxt.ex_pc = s_r.pm.addr;
        s_nxt.ex_valid = s_r.ctrl[rca_pkg::CTRL_RUN];

        if (s_r.tbl == rca_pkg::TBL_WAIT) begin
            // Refetch the word displaced by the table access
            s_nxt.pm.addr = s_r.resume;
            s_nxt.ex_valid = 1'b0;
            s_nxt.tbl = rca_pkg::TBL_DATA;
        end else if (s_r.tbl == rca_pkg::TBL_DATA) begin
            if (s_r.tbl_read) begin
                wr_en = 1'b1;
                wr_addr = s_r.tbl_dst;
                wr_val = s_r.tbl_hi ? pm_rdata[15:8] : pm_rdata[7:0];
            end
            s_nxt.tbl = rca_pkg::TBL_IDLE;
        end else if (!s_r.ctrl[rca_pkg::CTRL_RUN]) begin
            // Park on the unexecuted word so a restart loses nothing
            s_nxt.pm.addr = s_r.ex_valid ? s_r.ex_pc : s_r.pm.addr;
            s_nxt.ex_valid = 1'b0;
        end else if (s_r.ex_valid) begin
            unique case (op)
                rca_pkg::OP_ALU_F, rca_pkg::OP_ALU_L: begin
                    alu_en = 1'b1;
                    unique case (fn)
                        rca_pkg::FN_ADD:  alu = alu_add(b_in, acc, 1'b0);
                        rca_pkg::FN_ADDC: alu = alu_add(b_in, acc, flags[rca_pkg::FLG_C]);
                        rca_pkg::FN_SUB:  alu = alu_add(b_in, ~acc, 1'b1);
                        rca_pkg::FN_SUBB: alu = alu_add(b_in, ~acc, flags[rca_pkg::FLG_C]);
                        rca_pkg::FN_AND:  alu = alu_logic(b_in & acc);
                        rca_pkg::FN_OR:   alu = alu_logic(b_in | acc);
                        rca_pkg::FN_XOR:  alu = alu_logic(b_in ^ acc);
                        rca_pkg::FN_MOV:  alu = alu_logic(b_in);
                    endcase
                end
                rca_pkg::OP_SHF: begin
                    alu_en = 1'b1;
                    unique case (fn)
                        rca_pkg::SH_RLC: begin
                            alu = alu_logic({b_in[6:0], flags[rca_pkg::FLG_C]});
                            alu.c = b_in[7];
                            alu.upd_c = 1'b1;
                        end
                        rca_pkg::SH_RRC: begin
                            alu = alu_logic({flags[rca_pkg::FLG_C], b_in[7:1]});
                            alu.c = b_in[0];
                            alu.upd_c = 1'b1;
                        end
                        rca_pkg::SH_RL:  alu = alu_logic({b_in[6:0], b_in[7]});
                        rca_pkg::SH_RR:  alu = alu_logic({b_in[0], b_in[7:1]});
                        rca_pkg::SH_INC: alu = alu_add(b_in, 8'h01, 1'b0);
                        rca_pkg::SH_DEC: alu = alu_add(b_in, 8'hFF, 1'b0);
                        rca_pkg::SH_CLR: alu = alu_logic(8'h00);
                        rca_pkg::SH_COM: alu = alu_logic(~b_in);
                    endcase
                end
                rca_pkg::OP_MOVFF: begin
                    // Direct file-to-file path, not through the accumulator; it changes only when it is the destination
                    wr_en = 1'b1;
                    wr_addr = fa;
                    wr_val = rd_file(mv_src);
                end
                rca_pkg::OP_MUL: begin
                    s_nxt.dmem[rca_pkg::SFR_PRODL] = prod[7:0];
                    s_nxt.dmem[rca_pkg::SFR_PRODH] = prod[15:8];
                end
                rca_pkg::OP_GOTO: begin
                    redirect = 1'b1;
                    target = {s_r.dmem[rca_pkg::SFR_PCH][3:0], ir[11:0]};
                end
                rca_pkg::OP_SKIP: begin
                    squash = (flags[ir[1:0]] == ir[2]);
                end
                rca_pkg::OP_TBLRD, rca_pkg::OP_TBLWR: begin
                    // Borrow the program bus; costs two extra cycles
                    s_nxt.pm.addr = {s_r.dmem[rca_pkg::SFR_TBLH], s_r.dmem[rca_pkg::SFR_TBLL]};
                    s_nxt.pm.we = (op == rca_pkg::OP_TBLWR);
                    s_nxt.pm.wdata = {opnd, acc};
                    s_nxt.ex_valid = 1'b0;
                    s_nxt.resume = s_r.pm.addr;
                    s_nxt.tbl = rca_pkg::TBL_WAIT;
                    s_nxt.tbl_read = (op == rca_pkg::OP_TBLRD);
                    s_nxt.tbl_hi = ir[8];
                    s_nxt.tbl_dst = fa;
                    events[rca_pkg::IRQ_TBLWR] = (op == rca_pkg::OP_TBLWR);
                end
                default: begin
                    events[rca_pkg::IRQ_BADOP] = 1'b1;
                end
            endcase
        end

        if (alu_en) begin
            if (alu.upd_c) begin
                s_nxt.dmem[rca_pkg::SFR_FLAGS][rca_pkg::FLG_C] = alu.c;
            end
            if (alu.upd_arith) begin
                s_nxt.dmem[rca_pkg::SFR_FLAGS][rca_pkg::FLG_HC] = alu.hc;
                s_nxt.dmem[rca_pkg::SFR_FLAGS][rca_pkg::FLG_SW] = alu.sw;
                events[rca_pkg::IRQ_WRAP] = alu.sw;
            end
            s_nxt.dmem[rca_pkg::SFR_FLAGS][rca_pkg::FLG_Z] = (alu.res == 8'h00);
            wr_en = 1'b1;
            wr_addr = (op == rca_pkg::OP_ALU_L || !ir[8]) ? rca_pkg::SFR_ACC : fa;
            wr_val = alu.res;
        end

        // Stored result wins over a flag update to the same register
        if (wr_en) begin
            if (wr_addr == rca_pkg::SFR_PCL) begin
                redirect = 1'b1;
                target = {s_r.dmem[rca_pkg::SFR_PCH], wr_val};
            end else if (wr_addr != rca_pkg::SFR_IND) begin
                s_nxt.dmem[wr_addr] = wr_val;
            end
        end

        if (redirect) begin
            s_nxt.pm.addr = target;
            s_nxt.ex_valid = 1'b0;
        end else if (squash) begin
            s_nxt.ex_valid = 1'b0;
        end

        // Program source follows the next fetch address
        unique case (s_r.ctrl[rca_pkg::CTRL_MODE +: 2])
            rca_pkg::MODE_EXT: s_nxt.pm.ext_sel = 1'b1;
            rca_pkg::MODE_MIX: s_nxt.pm.ext_sel = (s_nxt.pm.addr > rca_pkg::PM_INT_TOP);
            default:           s_nxt.pm.ext_sel = 1'b0;
        endcase
        s_nxt.pm.protect = s_r.ctrl[rca_pkg::CTRL_PROT]
                           && (s_r.ctrl[rca_pkg::CTRL_MODE +: 2] != rca_pkg::MODE_MIX);

        // Register bus: write side
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = rca_pkg::RESP_OKAY;
            unique case (s_r.aw_addr)
                rca_pkg::REG_CTRL: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.ctrl = s_r.wdata[7:0];
                    end
                end
                rca_pkg::REG_IRQ_MASK: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.irq_mask = s_r.wdata[7:0];
                    end
                end
                rca_pkg::REG_STATUS, rca_pkg::REG_PC, rca_pkg::REG_ACC, rca_pkg::REG_IRQ_STAT: begin
                    s_nxt.bresp = rca_pkg::RESP_OKAY;
                end
                default: s_nxt.bresp = rca_pkg::RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
        end

        // Register bus: read side
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = rca_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                rca_pkg::REG_CTRL:     s_nxt.rdata = {24'h000000, s_r.ctrl};
                rca_pkg::REG_STATUS:   s_nxt.rdata = {16'h0000, flags, 4'h0,
                                                      (s_r.tbl != rca_pkg::TBL_IDLE), s_r.pm.protect,
                                                      s_r.pm.ext_sel, s_r.ctrl[rca_pkg::CTRL_RUN]};
                rca_pkg::REG_PC:       s_nxt.rdata = {16'h0000, s_r.ex_pc};
                rca_pkg::REG_ACC:      s_nxt.rdata = {24'h000000, acc};
                rca_pkg::REG_IRQ_STAT: begin
                    s_nxt.rdata = {24'h000000, s_r.irq_stat};
                    rd_clear = 1'b1;
                end
                rca_pkg::REG_IRQ_MASK: s_nxt.rdata = {24'h000000, s_r.irq_mask};
                default: begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = rca_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read clears, but an event in the same cycle survives
        s_nxt.irq_stat = (rd_clear ? 8'h00 : s_r.irq_stat) | events;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.ctrl <= rca_pkg::CTRL_RST;
            s_r.irq_mask <= rca_pkg::MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign pm_req        = s_r.pm;
    assign irq           = s_r.irq;

endmodule // rca_core

/* File: rca_pm_model.sv */
/* Program memory model: 64K words, registered read.
   Assumes pm_req from rca_core on the same aclk. */
`timescale 1ns/100ps
module rca_pm_model (
    input  wire logic              aclk,
    input  rca_pkg::rca_pm_req_type pm_req,
    output logic [15:0]            pm_rdata
);
    logic [15:0] mem [0:65535];
    // Plain always: the bench loads words here too
    always @(posedge aclk) begin
        if (pm_req.we) begin
            mem[pm_req.addr] <= pm_req.wdata;
        end
        pm_rdata <= mem[pm_req.addr];
    end
endmodule // rca_pm_model

/* File: rca_core_checker.sv */
/* Port checks on rca_core.
   Assumes one clock aclk and synchronous aresetn. */
`timescale 1ns/100ps
module rca_core_checker (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic [7:0]              s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input rca_pkg::rca_pm_req_type      pm_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answering");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WR_ANS: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write answered before both channels");
    AST_BAD_ADDR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
        |=> s_axi_rresp == rca_pkg::RESP_SLVERR) else $error("unmapped read not refused");
    AST_WE_PULSE: assert property (pm_req.we |=> !pm_req.we)
        else $error("table write strobe too long");
endmodule // rca_core_checker
bind rca_core rca_core_checker u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_req);

/* File: rca_core_bench.sv */
/* Self-checking bench for rca_core: runs short programs, reads results over AXI4-Lite.
   Assumes rca_pm_model as program memory. */
`timescale 1ns/100ps
module rca_core_bench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, a, b;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] pm_rdata;
    logic [2:0]  fn;
    logic [11:0] ex;
    rca_pkg::rca_pm_req_type pm_req;
    int          errors, n_compared;
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    rca_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_req, .pm_rdata, .irq);
    rca_pm_model u_pm (.aclk, .pm_req, .pm_rdata);
    task automatic give_verdict;
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic hang(input logic done);
        if (!done) begin
            errors++;
            $display("wrong value at %0t: bus wait ran out", $time);
            give_verdict();
        end
    endtask
    // Each task starts one edge late so no strobe is set twice in a step
    task automatic axw(input logic [7:0] ad, input logic [31:0] d);
        int n;
        logic ha, hw, hb;
        @(posedge aclk);
        n = 0;
        hb = 1'b0;
        s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!hb && n < 40) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready; hw = s_axi_wvalid && s_axi_wready; hb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        hang(hb);
    endtask
    task automatic axr(input logic [7:0] ad);
        int n;
        logic ha, hr;
        @(posedge aclk);
        n = 0;
        hr = 1'b0;
        s_axi_araddr <= ad; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!hr && n < 40) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready; hr = s_axi_rvalid; rd = s_axi_rdata; rs = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        hang(hr);
    endtask
    // Returns {wrap, zero, half carry, carry, result}; subtraction is literal minus accumulator
    // Carry in is zero here: only a move runs before the operation after reset
    function automatic logic [11:0] alu_exp(input logic [2:0] f, input logic [7:0] x, input logic [7:0] y);
        logic [7:0] o;
        logic [8:0] s;
        logic [4:0] h;
        logic       ci;
        ci = (f == rca_pkg::FN_SUB);
        o = (ci || f == rca_pkg::FN_SUBB) ? ~x : x;
        s = {1'b0, y} + {1'b0, o} + 9'(ci);
        h = {1'b0, y[3:0]} + {1'b0, o[3:0]} + 5'(ci);
        if (f == rca_pkg::FN_AND) s[7:0] = x & y;
        if (f == rca_pkg::FN_OR) s[7:0] = x | y;
        if (f == rca_pkg::FN_XOR) s[7:0] = x ^ y;
        if (f == rca_pkg::FN_MOV) s[7:0] = y;
        return {(y[7] == o[7]) && (s[7] != y[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction
    task automatic trial(input logic [15:0] w1, input logic [15:0] w2, input logic [7:0] ea, input logic [3:0] ef,
        input logic [3:0] fm);
        u_pm.mem[0] = {rca_pkg::OP_ALU_L, rca_pkg::FN_MOV, 1'b0, a};
        u_pm.mem[1] = w1;
        u_pm.mem[2] = w2;
        for (int k = 3; k < 6; k++) u_pm.mem[k] = 16'h5003;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axw(rca_pkg::REG_CTRL, 32'h1);
        repeat (12) @(posedge aclk);
        axr(rca_pkg::REG_ACC);
        chk(rd, 32'(ea));
        axr(rca_pkg::REG_STATUS);
        chk(32'(rd[11:8] & fm), 32'(ef & fm));
    endtask
    initial begin
        aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
        errors = 0;
        n_compared = 0;
        void'($urandom(32'h74C8));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            fn = (i < 2) ? rca_pkg::FN_ADD : 3'($urandom_range(7, 1));
            a = (i == 0) ? 8'hFF : 8'($urandom);
            b = (i == 0) ? 8'h01 : 8'($urandom);
            ex = alu_exp(fn, a, b);
            trial({rca_pkg::OP_ALU_L, fn, 1'b0, b}, 16'h5003, ex[7:0], ex[11:8], fn > 3'h3 ? 4'h4 : 4'hF);
        end
        a = 8'($urandom);
        trial({rca_pkg::OP_MUL, 4'h0, rca_pkg::SFR_ACC}, {rca_pkg::OP_MOVFF, 4'h7, rca_pkg::SFR_ACC},
            8'((16'(a) * 16'(a)) >> 8), {1'b0, a == 8'h00, 2'b00}, 4'hF);
        a = 8'h7F;
        trial({rca_pkg::OP_ALU_L, rca_pkg::FN_ADD, 1'b0, 8'h01}, 16'h5003, 8'h80, 4'hA, 4'hF);
        chk(32'(irq), 32'h0);
        axw(rca_pkg::REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        axr(rca_pkg::REG_IRQ_STAT);
        chk(32'(rd[0]), 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        axr(8'h40);
        chk(32'(rs), 32'(rca_pkg::RESP_SLVERR));
        axw(8'h40, 32'h5);
        chk(32'(rs), 32'(rca_pkg::RESP_SLVERR));
        a = 8'($urandom);
        trial({rca_pkg::OP_TBLWR, 4'h0, rca_pkg::SFR_ACC}, 16'h9000, a, {1'b0, a == 8'h00, 2'b00}, 4'hF);
        chk(32'(u_pm.mem[0]), 32'({a, a}));
        axr(rca_pkg::REG_IRQ_STAT);
        chk(32'(rd[2:0]), 32'h6);
        // External source with protection, then mixed mode, which drops protection
        axw(rca_pkg::REG_CTRL, 32'hB);
        axr(rca_pkg::REG_STATUS);
        chk(32'(rd[2:1]), 32'h3);
        axw(rca_pkg::REG_CTRL, 32'hD);
        axr(rca_pkg::REG_STATUS);
        chk(32'(rd[2:1]), 32'h0);
        give_verdict();
    end
endmodule // rca_core_bench
